// [rtl/tsi_defines.vh]
// Register map, field positions and reset values of the connection and output control block.
`ifndef TSI_DEFINES_VH
`define TSI_DEFINES_VH

// ******************************************************
// Register byte addresses
// ******************************************************
`define ADDR_CTRL       13'h0000
`define ADDR_FAR        13'h0004
`define ADDR_IRQ_STAT   13'h0008
`define ADDR_IRQ_MASK   13'h000C
`define ADDR_CM_BASE    13'h1000
`define ADDR_CM_SEL     12
`define ADDR_W          13

// ******************************************************
// Control word fields
// ******************************************************
`define CTRL_STANDBY    3
`define CTRL_SFE        2
`define CTRL_RESET      16'h0000

// ******************************************************
// Frame alignment word fields
// ******************************************************
`define FAR_DONE        12
`define FAR_FD_W        12

// ******************************************************
// Connection word fields
// ******************************************************
`define CW_LOOPBACK_SEL         15
`define CW_VAR          14
`define CW_PC           13
`define CW_OE           12
`define CW_SAB_HI       11
`define CW_SAB_LO       7
`define CW_CAB_HI       4
`define CW_CAB_LO       0

// ******************************************************
// Interrupt status bits and bus responses
// ******************************************************
`define IRQ_EVAL_DONE   0
`define IRQ_FRAME       1
`define IRQ_W           2
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// [rtl/tdm_timing.v]
// Bit-rate divider and bit, channel and frame counters of the serial streams.
`timescale 1ns/1ps
module tdm_timing #(
   parameter DIV = 12
) (
   input  wire       aclk,
   input  wire       aresetn,
   output reg        bit_en,
   output reg  [2:0] bit_q,
   output reg  [4:0] chan_q,
   output reg        page_q,
   output wire       slot_end,
   output wire       frame_end
);
   reg [15:0] div_q;

   assign slot_end  = bit_en & (bit_q == 3'h7);
   assign frame_end = slot_end & (chan_q == 5'h1F);

   always @(posedge aclk) begin
      if (!aresetn) begin
         div_q  <= 16'h0000;
         bit_en <= 1'b0;
         bit_q  <= 3'h0;
         chan_q <= 5'h00;
         page_q <= 1'b0;
      end else begin
         bit_en <= (div_q == DIV[15:0] - 16'h0001);
         div_q  <= (div_q == DIV[15:0] - 16'h0001) ? 16'h0000 : div_q + 16'h0001;
         if (bit_en) begin
            bit_q <= bit_q + 3'h1;
            if (slot_end) begin
               chan_q <= chan_q + 5'h01;
            end
            if (frame_end) begin
               page_q <= ~page_q;
            end
         end
      end
   end
endmodule // tdm_timing

// [rtl/axil_slave.v]
// AXI4-Lite slave that turns bus writes into single-cycle register strobes and reads into a held register address.
`timescale 1ns/1ps
`include "tsi_defines.vh"
module axil_slave (
   input  wire                 aclk,
   input  wire                 aresetn,
   input  wire [`ADDR_W-1:0]   awaddr,
   input  wire                 awvalid,
   output reg                  awready,
   input  wire [31:0]          wdata,
   input  wire [3:0]           wstrb,
   input  wire                 wvalid,
   output reg                  wready,
   output reg  [1:0]           bresp,
   output reg                  bvalid,
   input  wire                 bready,
   input  wire [`ADDR_W-1:0]   araddr,
   input  wire                 arvalid,
   output reg                  arready,
   output reg  [31:0]          rdata,
   output reg  [1:0]           rresp,
   output reg                  rvalid,
   input  wire                 rready,
   output wire                 reg_wr,
   output reg  [`ADDR_W-1:0]   reg_waddr,
   output reg  [31:0]          reg_wdata,
   output reg  [3:0]           reg_wstrb,
   input  wire                 reg_werr,
   output reg  [`ADDR_W-1:0]   reg_raddr,
   input  wire [31:0]          reg_rdata,
   input  wire                 reg_rerr
);
   reg rd_pend_q;

   // Both halves of a write are held until the response is taken.
   assign reg_wr = ~awready & ~wready & ~bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= `RESP_OKAY;
         arready   <= 1'b1;
         rvalid    <= 1'b0;
         rresp     <= `RESP_OKAY;
         rdata     <= 32'h00000000;
         rd_pend_q <= 1'b0;
         reg_waddr <= {`ADDR_W{1'b0}};
         reg_wdata <= 32'h00000000;
         reg_wstrb <= 4'h0;
         reg_raddr <= {`ADDR_W{1'b0}};
      end else begin
         if (awready & awvalid) begin
            awready   <= 1'b0;
            reg_waddr <= awaddr;
         end
         if (wready & wvalid) begin
            wready    <= 1'b0;
            reg_wdata <= wdata;
            reg_wstrb <= wstrb;
         end
         if (reg_wr) begin
            bvalid <= 1'b1;
            bresp  <= reg_werr ? `RESP_SLVERR : `RESP_OKAY;
         end
         if (bvalid & bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
         if (arready & arvalid) begin
            arready   <= 1'b0;
            reg_raddr <= araddr;
            rd_pend_q <= 1'b1;
         end
         if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            rvalid    <= 1'b1;
            rdata     <= reg_rerr ? 32'h00000000 : reg_rdata;
            rresp     <= reg_rerr ? `RESP_SLVERR : `RESP_OKAY;
         end
         if (rvalid & rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule // axil_slave

// [rtl/tsi_connection_output_control.v]
// Per-channel connection memory, switching, loopback and output control of a 32-stream TDM switch.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tsi_defines.vh"

// Behaviour
// RULE_01: Pin low and standby 0 put all 32 serial outputs in high impedance.
// RULE_02: Outputs drive normally when pin high, or pin low with standby 1.
// RULE_03: Rising edge of start_frame_eval bit 2 launches frame evaluation.
// RULE_04: Evaluation ends when frame_eval_done rises from 0 to 1.
// RULE_05: Host keeps start_frame_eval at 0 a full frame before re-arming.
// RULE_06: Falling start_frame_eval clears frame_eval_done.
// RULE_07: Word bit 15 loops output stream n channel m into input n channel m.
// RULE_08: Host sets input offset fields to zero for looped streams.
// RULE_09: Word bit 13 sends the word's own low byte on that channel.
// RULE_10: With bit 13 clear the word addresses the switched input channel.
// RULE_11: Word bit 12 drives the channel when 1, high impedance when 0.
// RULE_12: Word bits 11-7 give the source input stream number.
// RULE_13: Word bits 4-0 give the source channel within that stream.
// RULE_14: Host writes zeros into word bits 6-5.
// RULE_15: Word bit 14 selects variable (1) or constant (0) throughput delay.
// RULE_16: Each output slot reads its word and applies it to the sent byte.
module tsi_connection_output_control #(
   parameter DIV = 12
) (
   input  wire                 aclk,
   input  wire                 aresetn,
   input  wire [`ADDR_W-1:0]   s_axi_awaddr,
   input  wire                 s_axi_awvalid,
   output wire                 s_axi_awready,
   input  wire [31:0]          s_axi_wdata,
   input  wire [3:0]           s_axi_wstrb,
   input  wire                 s_axi_wvalid,
   output wire                 s_axi_wready,
   output wire [1:0]           s_axi_bresp,
   output wire                 s_axi_bvalid,
   input  wire                 s_axi_bready,
   input  wire [`ADDR_W-1:0]   s_axi_araddr,
   input  wire                 s_axi_arvalid,
   output wire                 s_axi_arready,
   output wire [31:0]          s_axi_rdata,
   output wire [1:0]           s_axi_rresp,
   output wire                 s_axi_rvalid,
   input  wire                 s_axi_rready,
   input  wire                 output_drive_enable_pin,
   input  wire                 frame_sync_in,
   input  wire [31:0]          serial_in_stream,
   output reg  [31:0]          serial_out_stream,
   output reg  [31:0]          serial_out_oe_n,
   output reg                  irq
);
   // ******************************************************
   // Declarations
   // ******************************************************
   wire                 reg_wr;
   wire [`ADDR_W-1:0]   reg_waddr;
   wire [31:0]          reg_wdata;
   wire [3:0]           reg_wstrb;
   wire [`ADDR_W-1:0]   reg_raddr;
   reg  [31:0]          reg_rdata;
   reg                  reg_werr;
   reg                  reg_rerr;
   wire                 bit_en;
   wire [2:0]           bit_q;
   wire [4:0]           chan_q;
   wire                 page_q;
   wire                 slot_end;
   wire                 frame_end;
   reg  [15:0]          control_reg_q;
   reg                  sfe_prev_q;
   reg                  eval_busy_q;
   reg                  frame_eval_done_q;
   reg  [`FAR_FD_W-1:0] frame_delay_q;
   reg  [`IRQ_W-1:0]    irq_stat_q;
   reg  [`IRQ_W-1:0]    irq_mask_q;
   reg  [15:0]          cm [0:1023];
   reg  [7:0]           dm [0:2047];
   reg  [255:0]         tx_byte_q;
   reg  [255:0]         tx_sh_q;
   reg  [255:0]         rx_sh_q;
   reg  [31:0]          chan_oe_q;
   reg  [31:0]          loopback_sel_q;
   wire [255:0]         next_byte;
   wire [31:0]          next_oe;
   wire [31:0]          next_loopback_sel;
   wire [4:0]           chan_next;
   wire                 done_rise;
   wire                 sfe_rise;
   wire                 sfe_fall;
   wire                 drive_all;
   wire [15:0]          wr16;
   wire [15:0]          far_word;
   integer              s;

   // ******************************************************
   // Bus slave and stream timing
   // ******************************************************
   axil_slave u_bus (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .awaddr    (s_axi_awaddr),
      .awvalid   (s_axi_awvalid),
      .awready   (s_axi_awready),
      .wdata     (s_axi_wdata),
      .wstrb     (s_axi_wstrb),
      .wvalid    (s_axi_wvalid),
      .wready    (s_axi_wready),
      .bresp     (s_axi_bresp),
      .bvalid    (s_axi_bvalid),
      .bready    (s_axi_bready),
      .araddr    (s_axi_araddr),
      .arvalid   (s_axi_arvalid),
      .arready   (s_axi_arready),
      .rdata     (s_axi_rdata),
      .rresp     (s_axi_rresp),
      .rvalid    (s_axi_rvalid),
      .rready    (s_axi_rready),
      .reg_wr    (reg_wr),
      .reg_waddr (reg_waddr),
      .reg_wdata (reg_wdata),
      .reg_wstrb (reg_wstrb),
      .reg_werr  (reg_werr),
      .reg_raddr (reg_raddr),
      .reg_rdata (reg_rdata),
      .reg_rerr  (reg_rerr)
   );

   tdm_timing #(
      .DIV (DIV)
   ) u_timing (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .bit_en    (bit_en),
      .bit_q     (bit_q),
      .chan_q    (chan_q),
      .page_q    (page_q),
      .slot_end  (slot_end),
      .frame_end (frame_end)
   );

   // ******************************************************
   // Register decode
   // ******************************************************
   // Only the two low byte lanes carry register bits; the upper lanes are ignored.
   assign wr16 = {reg_wstrb[1] ? reg_wdata[15:8] : 8'h00, reg_wstrb[0] ? reg_wdata[7:0] : 8'h00};
   assign far_word = {3'h0, frame_eval_done_q, frame_delay_q};

   always @* begin
      reg_werr = 1'b0;
      if (!reg_waddr[`ADDR_CM_SEL] && (reg_waddr != `ADDR_CTRL) && (reg_waddr != `ADDR_FAR) &&
          (reg_waddr != `ADDR_IRQ_STAT) && (reg_waddr != `ADDR_IRQ_MASK)) begin
         reg_werr = 1'b1;
      end
      if (reg_waddr[1:0] != 2'h0) begin
         reg_werr = 1'b1;
      end
   end

   always @* begin
      reg_rerr  = 1'b0;
      reg_rdata = 32'h00000000;
      if (reg_raddr[`ADDR_CM_SEL]) begin
         reg_rdata = {16'h0000, cm[reg_raddr[11:2]]};
      end else begin
         case (reg_raddr)
            `ADDR_CTRL:     reg_rdata = {16'h0000, control_reg_q};
            `ADDR_FAR:      reg_rdata = {16'h0000, far_word};
            `ADDR_IRQ_STAT: reg_rdata = {30'h00000000, irq_stat_q};
            `ADDR_IRQ_MASK: reg_rdata = {30'h00000000, irq_mask_q};
            default:        reg_rerr  = 1'b1;
         endcase
      end
      if (reg_raddr[1:0] != 2'h0) begin
         reg_rerr  = 1'b1;
         reg_rdata = 32'h00000000;
      end
   end

   // ******************************************************
   // Control, frame evaluation and interrupts
   // ******************************************************
   assign sfe_rise  = control_reg_q[`CTRL_SFE] & ~sfe_prev_q;
   assign sfe_fall  = ~control_reg_q[`CTRL_SFE] & sfe_prev_q;
   assign done_rise = eval_busy_q & frame_sync_in;

   always @(posedge aclk) begin
      if (!aresetn) begin
         control_reg_q     <= `CTRL_RESET;
         sfe_prev_q        <= 1'b0;
         eval_busy_q       <= 1'b0;
         frame_eval_done_q <= 1'b0;
         frame_delay_q     <= {`FAR_FD_W{1'b0}};
         irq_stat_q        <= {`IRQ_W{1'b0}};
         irq_mask_q        <= {`IRQ_W{1'b0}};
         irq               <= 1'b0;
      end else begin
         sfe_prev_q <= control_reg_q[`CTRL_SFE];
         if (reg_wr && !reg_werr && reg_waddr == `ADDR_CTRL) begin
            control_reg_q <= wr16;
         end
         if (reg_wr && !reg_werr && reg_waddr == `ADDR_IRQ_MASK) begin
            irq_mask_q <= wr16[`IRQ_W-1:0];
         end
         if (reg_wr && !reg_werr && reg_waddr == `ADDR_IRQ_STAT) begin
            irq_stat_q <= irq_stat_q & ~wr16[`IRQ_W-1:0];
         end
         // RULE_03 evaluation launch
         if (sfe_rise) begin
            eval_busy_q <= 1'b1;
         end
         // RULE_06 done clear
         if (sfe_fall) begin
            eval_busy_q       <= 1'b0;
            frame_eval_done_q <= 1'b0;
         end
         // RULE_04 stop on done
         if (done_rise) begin
            eval_busy_q       <= 1'b0;
            frame_eval_done_q <= 1'b1;
            frame_delay_q     <= {4'h0, chan_q, bit_q};
         end
         // Hardware events win over a same-cycle clear by software.
         if (done_rise) begin
            irq_stat_q[`IRQ_EVAL_DONE] <= 1'b1;
         end
         if (frame_end) begin
            irq_stat_q[`IRQ_FRAME] <= 1'b1;
         end
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ******************************************************
   // Connection memory writes
   // ******************************************************
   always @(posedge aclk) begin
      if (reg_wr && !reg_werr && reg_waddr[`ADDR_CM_SEL]) begin
         cm[reg_waddr[11:2]] <= wr16;
      end
   end

   // ******************************************************
   // Per-stream connection lookup
   // ******************************************************
   assign chan_next = chan_q + 5'h01;

   genvar g;
   generate
      for (g = 0; g < 32; g = g + 1) begin : g_strm
         wire [15:0] word;
         wire [4:0]  src_s;
         wire [4:0]  src_c;
         wire        new_pg;
         wire        rd_pg;
         localparam [4:0] GS = g;
         // RULE_16 slot word fetch
         assign word = cm[{GS, chan_next}];
         // RULE_12 source stream
         assign src_s = word[`CW_SAB_HI:`CW_SAB_LO];
         // RULE_13 source channel
         assign src_c = word[`CW_CAB_HI:`CW_CAB_LO];
         // RULE_15 delay mode
         // Variable delay takes this frame's byte only once its slot is fully stored.
         assign new_pg = page_q ^ frame_end;
         assign rd_pg  = (word[`CW_VAR] && !frame_end && src_c < chan_q) ? new_pg : ~new_pg;
         // RULE_09 processor channel
         // RULE_10 switched data
         assign next_byte[g*8 +: 8] = word[`CW_PC] ? word[7:0] : dm[{rd_pg, src_s, src_c}];
         assign next_oe[g]          = word[`CW_OE];
         assign next_loopback_sel[g]        = word[`CW_LOOPBACK_SEL];
      end
   endgenerate

   // ******************************************************
   // Serial shifting, data memory and output drive
   // ******************************************************
   // RULE_01 standby tri-state
   // RULE_02 normal drive
   assign drive_all = output_drive_enable_pin | control_reg_q[`CTRL_STANDBY];

   always @(posedge aclk) begin
      if (bit_en && slot_end) begin
         for (s = 0; s < 32; s = s + 1) begin
            // RULE_07 loopback capture
            dm[{page_q, s[4:0], chan_q}] <= loopback_sel_q[s] ? tx_byte_q[s*8 +: 8] : {rx_sh_q[s*8 +: 7], serial_in_stream[s]};
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_byte_q         <= {256{1'b0}};
         tx_sh_q           <= {256{1'b0}};
         rx_sh_q           <= {256{1'b0}};
         chan_oe_q         <= 32'h00000000;
         loopback_sel_q            <= 32'h00000000;
         serial_out_stream <= 32'h00000000;
         serial_out_oe_n   <= 32'hFFFFFFFF;
      end else begin
         // RULE_11 per-channel enable
         serial_out_oe_n <= ~(chan_oe_q & {32{drive_all}});
         if (bit_en) begin
            for (s = 0; s < 32; s = s + 1) begin
               rx_sh_q[s*8 +: 8] <= {rx_sh_q[s*8 +: 7], serial_in_stream[s]};
               if (slot_end) begin
                  tx_byte_q[s*8 +: 8]  <= next_byte[s*8 +: 8];
                  tx_sh_q[s*8 +: 8]    <= {next_byte[s*8 +: 7], 1'b0};
                  serial_out_stream[s] <= next_byte[s*8+7];
               end else begin
                  tx_sh_q[s*8 +: 8]    <= {tx_sh_q[s*8 +: 7], 1'b0};
                  serial_out_stream[s] <= tx_sh_q[s*8+7];
               end
            end
            if (slot_end) begin
               chan_oe_q <= next_oe;
               loopback_sel_q    <= next_loopback_sel;
            end
         end
      end
   end
endmodule // tsi_connection_output_control

// [test/tsi_conn_chk.sv]
// Port assertions of the switch control block.
`timescale 1ns/1ps
`include "tsi_defines.vh"
module tsi_conn_chk #(
   parameter DIV = 12
) (
   input wire                 aclk,
   input wire                 aresetn,
   input wire [`ADDR_W-1:0]   s_axi_awaddr,
   input wire                 s_axi_awvalid,
   input wire                 s_axi_awready,
   input wire [31:0]          s_axi_wdata,
   input wire                 s_axi_wvalid,
   input wire                 s_axi_wready,
   input wire [1:0]           s_axi_bresp,
   input wire                 s_axi_bvalid,
   input wire                 s_axi_bready,
   input wire                 s_axi_arvalid,
   input wire                 s_axi_arready,
   input wire [31:0]          s_axi_rdata,
   input wire                 s_axi_rvalid,
   input wire                 s_axi_rready,
   input wire                 output_drive_enable_pin,
   input wire [31:0]          serial_out_stream,
   input wire [31:0]          serial_out_oe_n,
   input wire                 irq
);
   // ********************
   // Helper state
   // ********************
   // Standby shadow lags writes in flight.
   reg        a0_q;
   reg        wd_q;
   reg        stby_q;
   reg [7:0]  gap_q;
   reg [31:0] prev_q;
   wire       bit_chg = serial_out_stream != prev_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         a0_q   <= 1'b0;
         wd_q   <= 1'b0;
         stby_q <= 1'b0;
         gap_q  <= 8'hFF;
         prev_q <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) a0_q <= s_axi_awaddr == `ADDR_CTRL;
         if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[`CTRL_STANDBY];
         if (s_axi_bvalid && s_axi_bready && s_axi_bresp == `RESP_OKAY && a0_q) stby_q <= wd_q;
         gap_q  <= bit_chg ? 8'h00 : (gap_q == 8'hFF ? gap_q : gap_q + 8'h01);
         prev_q <= serial_out_stream;
      end
   end
   // ********************
   // Properties
   // ********************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_hiz_cond; !output_drive_enable_pin && !stby_q && s_axi_awready; endsequence
   sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
   property p_all_hiz; s_hiz_cond [*3] |-> serial_out_oe_n == 32'hFFFFFFFF; endproperty
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   property p_b_lat; s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
   property p_r_lat; s_rd_taken |=> !s_axi_rvalid ##1 s_axi_rvalid; endproperty
   property p_rd_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   property p_slverr;
      s_wr_taken and (s_axi_awaddr > `ADDR_IRQ_MASK && s_axi_awaddr < `ADDR_CM_BASE)
      |=> ##1 s_axi_bresp == `RESP_SLVERR;
   endproperty
   property p_bit_gap; bit_chg |-> gap_q >= 8'(DIV - 1); endproperty
   property p_rst_out; $rose(aresetn) |-> serial_out_oe_n == 32'hFFFFFFFF && !irq && serial_out_stream == 32'h0; endproperty
   a_all_hiz: assert property (p_all_hiz)
      else $error("outputs driven in standby");
   a_b_hold: assert property (p_b_hold)
      else $error("bresp not held");
   a_r_hold: assert property (p_r_hold)
      else $error("rdata not held");
   a_b_lat: assert property (p_b_lat)
      else $error("bvalid latency");
   a_r_lat: assert property (p_r_lat)
      else $error("rvalid latency");
   a_rd_busy: assert property (p_rd_busy)
      else $error("arready while rvalid");
   a_wr_busy: assert property (p_wr_busy)
      else $error("readies while bvalid");
   a_slverr: assert property (p_slverr)
      else $error("no slverr");
   a_bit_gap: assert property (p_bit_gap)
      else $error("bit period short");
   a_rst_out: assert property (p_rst_out)
      else $error("reset outputs");
endmodule // tsi_conn_chk
bind tsi_connection_output_control tsi_conn_chk #(.DIV(DIV)) u_chk (.*);

// [test/tdm_far_end.sv]
// Far-end devices: a fixed byte on every stream, a frame mark per frame.
`timescale 1ns/1ps
module tdm_far_end #(
   parameter int DIV = 4,
   parameter logic [7:0] BYTE = 8'h3C
) (
   input  wire logic        aclk,
   output logic [31:0]      serial_in_stream,
   output logic             frame_sync_in
);
   // Never reset: its phase is unrelated to the switch.
   logic [15:0]             c_q = 16'h0005;
   always @(posedge aclk) begin
      c_q <= (c_q == 16'(256 * DIV - 1)) ? 16'h0000 : c_q + 16'h0001;
   end
   assign serial_in_stream = {32{BYTE[3'd7 - 3'((c_q / DIV) % 8)]}};
   assign frame_sync_in    = c_q == 16'h0000;
endmodule // tdm_far_end

// [test/testbench.sv]
// Self-checking bench for the switch control block.
`timescale 1ns/1ps
`include "tsi_defines.vh"
module testbench;
   localparam int DIV = 4;
   localparam int FRAME = 256 * DIV;
   localparam logic [47:0] WDS = {16'h1007, 16'h1100, 16'h5100};
   localparam logic [23:0] EXB = {8'h81, 8'h3C, 8'h3C};
   logic                    aclk, aresetn, output_drive_enable_pin, frame_sync_in, irq;
   logic [`ADDR_W-1:0]      s_axi_awaddr, s_axi_araddr;
   logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                    s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0]             s_axi_wdata, s_axi_rdata, serial_in_stream, serial_out_stream, serial_out_oe_n;
   logic [3:0]              s_axi_wstrb;
   logic [1:0]              s_axi_bresp, s_axi_rresp;
   int                      miscompares, checks_done, cyc;
   tsi_connection_output_control #(.DIV(DIV)) dut (.*);
   tdm_far_end #(.DIV(DIV)) u_far (.*);
   // ********************
   // Tasks
   // ********************
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [12:0] cw(input int s, input int c);
      return `ADDR_CM_BASE + 13'(4 * (s * 32 + c));
   endfunction
   task automatic axi_wr(input logic [12:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Byte edges are invisible at the pins, so any rotation is accepted.
   task automatic chk_pat(input int s, input logic [7:0] b);
      logic [15:0] sh;
      logic        hit;
      repeat (3 * FRAME) @(posedge aclk);
      for (int i = 0; i < 16; i++) begin
         repeat (DIV) @(posedge aclk);
         sh = {sh[14:0], serial_out_stream[s]};
      end
      hit = 1'b0;
      for (int k = 0; k < 8; k++) if (sh[k +: 8] === b) hit = 1'b1;
      chk("pattern", {24'h0, b}, {24'h0, hit ? b : sh[7:0]});
   endtask
   // ********************
   // Clock, timeout and sequence
   // ********************
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 80000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      output_drive_enable_pin = 1'b1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(`ADDR_CTRL, d, r);
      chk("ctrl", 32'h0, d);
      axi_rd(`ADDR_FAR, d, r);
      chk("far_done", 32'h0, {31'h0, d[`FAR_DONE]});
      axi_rd(13'h0010, d, r);
      chk("rd_resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
      axi_wr(13'h0010, 32'h1, `RESP_SLVERR);
      for (int c = 0; c < 32; c++) begin
         axi_wr(cw(0, c), 32'h0000B099, `RESP_OKAY);
         axi_wr(cw(1, c), 32'h0, `RESP_OKAY);
      end
      chk_pat(0, 8'h99);
      chk("oe_n_chan", 32'h2, {30'h0, serial_out_oe_n[1:0]});
      output_drive_enable_pin <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("oe_n_hiz", 32'hFFFFFFFF, serial_out_oe_n);
      axi_wr(`ADDR_CTRL, 32'h8, `RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("oe_n_stby", 32'h2, {30'h0, serial_out_oe_n[1:0]});
      axi_wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      output_drive_enable_pin <= 1'b1;
      axi_wr(cw(0, 7), 32'h0000B081, `RESP_OKAY);
      axi_wr(cw(2, 0), 32'h0, `RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         for (int c = 0; c < 32; c++) axi_wr(cw(1, c), {16'h0, WDS[47-16*k -: 16]}, `RESP_OKAY);
         chk_pat(1, EXB[23-8*k -: 8]);
      end
      chk("irq_masked", 32'h0, {31'h0, irq});
      axi_wr(`ADDR_IRQ_MASK, 32'h1, `RESP_OKAY);
      for (int n = 0; n < 2; n++) begin
         axi_wr(`ADDR_CTRL, 32'h4, `RESP_OKAY);
         d = 32'h0;
         repeat (400) if (d[`FAR_DONE] !== 1'b1) axi_rd(`ADDR_FAR, d, r);
         chk("far_done", 32'h1, {31'h0, d[`FAR_DONE]});
         axi_rd(`ADDR_IRQ_STAT, d, r);
         chk("stat_eval", 32'h1, {31'h0, d[`IRQ_EVAL_DONE]});
         chk("irq_set", 32'h1, {31'h0, irq});
         axi_wr(`ADDR_IRQ_STAT, 32'h1, `RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk("irq_clr", 32'h0, {31'h0, irq});
         axi_wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
         axi_rd(`ADDR_FAR, d, r);
         chk("far_clr", 32'h0, {31'h0, d[`FAR_DONE]});
         repeat (FRAME + 8) @(posedge aclk);
      end
      end_sim();
   end
endmodule // testbench
